// File: gei_cpu_model.sv
// Processor-side interrupt sink: remembers which request lines were ever raised.
// Assumes the request lines are levels synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none

module gei_cpu_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Request lines
  input wire logic irq_low_i,
  input wire logic irq_high_i,
  // Observations
  output logic seen_low_o,
  output logic seen_high_o
);
  // Sticky, so short requests between polls are not lost
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      seen_low_o <= 1'b0;
      seen_high_o <= 1'b0;
    end
    else
    begin
      seen_low_o <= seen_low_o | irq_low_i;
      seen_high_o <= seen_high_o | irq_high_i;
    end
  end
endmodule

`default_nettype wire

// File: gei_map.svh
// Register map, field positions, reset values and codes of the event interrupt controller.
// Assumes inclusion by its bare name from the package and from the top module.
`ifndef GEI_MAP_SVH
`define GEI_MAP_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define GEI_ADDR_W 8
`define GEI_DATA_W 32
`define GEI_NSRC 42
`define GEI_LO_W 32
`define GEI_HI_W 10
`define GEI_CODE_W 6
`define GEI_QDEPTH_LOG2 6

// ----------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------
`define GEI_OFS_FWD_LO 8'h00
`define GEI_OFS_FWD_HI 8'h04
`define GEI_OFS_LVL_LO 8'h08
`define GEI_OFS_LVL_HI 8'h0C
`define GEI_OFS_WAIT_LO 8'h10
`define GEI_OFS_WAIT_HI 8'h14
`define GEI_OFS_ACK_LO 8'h18
`define GEI_OFS_ACK_HI 8'h1C
`define GEI_OFS_QLOW 8'h20
`define GEI_OFS_QHIGH 8'h24
`define GEI_OFS_QSTAT 8'h28

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define GEI_FWD_RST 42'h0
`define GEI_LVL_RST 42'h0
`define GEI_WAIT_RST 42'h0
`define GEI_CODE_EMPTY 6'h3F

// ----------------------------------------------------------------
// Queue status fields
// ----------------------------------------------------------------
`define GEI_STAT_OVF_LOW_BIT 15
`define GEI_STAT_OVF_HIGH_BIT 14
`define GEI_STAT_FILL_LOW_LSB 7
`define GEI_STAT_FILL_HIGH_LSB 0

`endif

// File: gei_pkg.sv
// Types shared by the event interrupt controller files.
// Assumes gei_map.svh is on the include path.
`include "gei_map.svh"

package gei_pkg;

  typedef logic [`GEI_NSRC-1:0] gei_src_t;
  typedef logic [`GEI_CODE_W-1:0] gei_code_t;

  typedef enum {
    GEI_REG_FWD_LO,
    GEI_REG_FWD_HI,
    GEI_REG_LVL_LO,
    GEI_REG_LVL_HI,
    GEI_REG_WAIT_LO,
    GEI_REG_WAIT_HI,
    GEI_REG_ACK_LO,
    GEI_REG_ACK_HI,
    GEI_REG_QLOW,
    GEI_REG_QHIGH,
    GEI_REG_QSTAT,
    GEI_REG_NONE
  } gei_reg_t;

endpackage

// File: gei_queue_ram.sv
// Small simple dual-port memory for one event queue, read data registered.
// Assumes one clock; contents are not reset, only the read register is.
`timescale 1ns/1ps
`default_nettype none

module gei_queue_ram #(
  parameter int WIDTH = 6,
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Write side
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Read side
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [1<<AW];

  always_ff @(posedge clock_i)
  begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
  end

  // Read every cycle; the caller only looks when it asked
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else
      rdata_o <= mem[raddr_i];
  end

endmodule

`default_nettype wire

// File: gei_top.sv
// Event interrupt controller of the correlator core: 42 sources, two event queues.
// Assumes events are one-cycle pulses from logic on clock_i and a one-cycle register port.
//
// Contract
// - Forwarding bit 0: event only marks waiting, nothing goes to processor.
// - Forwarding bit 1: event is queued and raises a processor interrupt request.
// - Low words: bit n belongs to tracking channel n, channels 0 to 31.
// - High words: channels 32-35, then second pulse, antenna, epoch, detectors, transfer error.
// - Level bit 0 selects low level, 1 high level; readable and writable.
// - Waiting bits read-only, 1 while event unacknowledged, independent of forwarding.
// - After reset all forwarding, level and waiting bits are zero.
// - Writing 1 to an acknowledge bit clears that waiting bit; 0 leaves it.
// - Queue read returns 6-bit source code; 63 means queue empty.
// - Each queue holds 64 entries, reports fill; overflow flag sticky, write-1 clears.
`timescale 1ns/1ps
`default_nettype none
`include "gei_map.svh"

module gei_top
  import gei_pkg::*;
#(
  parameter int QAW = `GEI_QDEPTH_LOG2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [`GEI_ADDR_W-1:0] addr_i,
  input wire logic [`GEI_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`GEI_DATA_W-1:0] rdata_o,
  // Event sources
  input wire logic [35:0] channel_event_i,
  input wire logic pulse_per_second_i,
  input wire logic antenna_switch_epoch_i,
  input wire logic measurement_epoch_i,
  input wire logic power_detector_real_i,
  input wire logic power_detector_complex_i,
  input wire logic transfer_error_i,
  // Interrupt requests
  output logic processor_irq_o,
  output logic irq_low_o,
  output logic irq_high_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam logic [QAW:0] QFULL = {1'b1, {QAW{1'b0}}};

  function automatic gei_reg_t reg_decode(input logic [`GEI_ADDR_W-1:0] a);
    gei_reg_t r;
    case (a)
      `GEI_OFS_FWD_LO: r = GEI_REG_FWD_LO;
      `GEI_OFS_FWD_HI: r = GEI_REG_FWD_HI;
      `GEI_OFS_LVL_LO: r = GEI_REG_LVL_LO;
      `GEI_OFS_LVL_HI: r = GEI_REG_LVL_HI;
      `GEI_OFS_WAIT_LO: r = GEI_REG_WAIT_LO;
      `GEI_OFS_WAIT_HI: r = GEI_REG_WAIT_HI;
      `GEI_OFS_ACK_LO: r = GEI_REG_ACK_LO;
      `GEI_OFS_ACK_HI: r = GEI_REG_ACK_HI;
      `GEI_OFS_QLOW: r = GEI_REG_QLOW;
      `GEI_OFS_QHIGH: r = GEI_REG_QHIGH;
      `GEI_OFS_QSTAT: r = GEI_REG_QSTAT;
      default: r = GEI_REG_NONE;
    endcase
    return r;
  endfunction

  // Lowest index wins when several sources wait for the same queue
  function automatic gei_code_t first_set(input gei_src_t v);
    gei_code_t code;
    code = `GEI_CODE_EMPTY;
    for (int i = `GEI_NSRC - 1; i >= 0; i--)
      if (v[i])
        code = gei_code_t'(i);
    return code;
  endfunction

  // ----------------------------------------------------------------
  // Source vector
  // ----------------------------------------------------------------
  gei_src_t src_evt;
  gei_reg_t sel;

  assign src_evt = {transfer_error_i,
                    power_detector_complex_i,
                    power_detector_real_i,
                    measurement_epoch_i,
                    antenna_switch_epoch_i,
                    pulse_per_second_i,
                    channel_event_i};
  assign sel = reg_decode(addr_i);

  // ----------------------------------------------------------------
  // Control and waiting state
  // ----------------------------------------------------------------
  gei_src_t fwd_ff;
  gei_src_t nxt_fwd;
  gei_src_t lvl_ff;
  gei_src_t nxt_lvl;
  gei_src_t wait_ff;
  gei_src_t nxt_wait;
  gei_src_t ack_vec;
  logic [1:0] ovf_clr;

  always_comb
  begin
    nxt_fwd = fwd_ff;
    nxt_lvl = lvl_ff;
    ack_vec = '0;
    ovf_clr = 2'h0;
    if (wr_i)
    begin
      case (sel)
        GEI_REG_FWD_LO: nxt_fwd[`GEI_LO_W-1:0] = wdata_i;
        GEI_REG_FWD_HI: nxt_fwd[`GEI_NSRC-1:`GEI_LO_W] = wdata_i[`GEI_HI_W-1:0];
        GEI_REG_LVL_LO: nxt_lvl[`GEI_LO_W-1:0] = wdata_i;
        GEI_REG_LVL_HI: nxt_lvl[`GEI_NSRC-1:`GEI_LO_W] = wdata_i[`GEI_HI_W-1:0];
        GEI_REG_ACK_LO: ack_vec[`GEI_LO_W-1:0] = wdata_i;
        GEI_REG_ACK_HI: ack_vec[`GEI_NSRC-1:`GEI_LO_W] = wdata_i[`GEI_HI_W-1:0];
        GEI_REG_QSTAT:
        begin
          ovf_clr[0] = wdata_i[`GEI_STAT_OVF_LOW_BIT];
          ovf_clr[1] = wdata_i[`GEI_STAT_OVF_HIGH_BIT];
        end
        default: ;
      endcase
    end
    // New event beats a simultaneous acknowledge, whatever the forwarding bit
    nxt_wait = (wait_ff & ~ack_vec) | src_evt;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      fwd_ff <= `GEI_FWD_RST;
      lvl_ff <= `GEI_LVL_RST;
      wait_ff <= `GEI_WAIT_RST;
    end
    else
    begin
      fwd_ff <= nxt_fwd;
      lvl_ff <= nxt_lvl;
      wait_ff <= nxt_wait;
    end
  end

  // ----------------------------------------------------------------
  // Event queues: index 0 low level, index 1 high level
  // ----------------------------------------------------------------
  logic [1:0] pop;
  wire logic [1:0] q_empty;
  wire logic [1:0] q_ovf;
  wire logic [QAW:0] q_fill [2];
  wire gei_code_t q_rdata [2];

  for (genvar g = 0; g < 2; g++)
  begin : g_queue
    gei_src_t req_ff;
    gei_src_t nxt_req;
    gei_src_t cand;
    gei_src_t taken;
    logic [QAW:0] wptr_ff;
    logic [QAW:0] nxt_wptr;
    logic [QAW:0] rptr_ff;
    logic [QAW:0] nxt_rptr;
    logic [QAW:0] fill;
    logic ovf_ff;
    logic nxt_ovf;
    logic req_any;
    logic room;
    logic push;
    gei_code_t push_code;

    always_comb
    begin
      // Only forwarded events reach a queue; unforwarded ones stay waiting only
      cand = src_evt & fwd_ff & ((g == 0) ? ~lvl_ff : lvl_ff);
      fill = wptr_ff - rptr_ff;
      req_any = |req_ff;
      push_code = first_set(req_ff);
      // A pop in the same cycle frees the slot for the push
      room = (fill != QFULL) || pop[g];
      push = req_any && room;
      taken = req_any ? (gei_src_t'(1) << push_code) : '0;
      // Repeats before the entry is written merge into one queue entry
      nxt_req = (req_ff & ~taken) | cand;
      nxt_wptr = push ? wptr_ff + 1'b1 : wptr_ff;
      nxt_rptr = pop[g] ? rptr_ff + 1'b1 : rptr_ff;
      // Entry that finds the queue full is dropped; setting beats clearing
      nxt_ovf = (ovf_ff && !ovf_clr[g]) || (req_any && !room);
    end

    always_ff @(posedge clock_i)
    begin
      if (!rst_n_i)
      begin
        req_ff <= '0;
        wptr_ff <= '0;
        rptr_ff <= '0;
        ovf_ff <= 1'b0;
      end
      else
      begin
        req_ff <= nxt_req;
        wptr_ff <= nxt_wptr;
        rptr_ff <= nxt_rptr;
        ovf_ff <= nxt_ovf;
      end
    end

    gei_queue_ram #(
      .WIDTH(`GEI_CODE_W),
      .AW(QAW)
    ) u_ram (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .we_i(push),
      .waddr_i(wptr_ff[QAW-1:0]),
      .wdata_i(push_code),
      .raddr_i(rptr_ff[QAW-1:0]),
      .rdata_o(q_rdata[g])
    );

    assign q_empty[g] = (fill == '0);
    assign q_ovf[g] = ovf_ff;
    assign q_fill[g] = fill;
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [`GEI_DATA_W-1:0] rdata_ff;
  logic [`GEI_DATA_W-1:0] nxt_rdata;
  logic [1:0] qsel_ff;
  logic [1:0] nxt_qsel;
  logic [`GEI_HI_W-1:0] wait_hi_snap_ff;
  logic [`GEI_HI_W-1:0] nxt_wait_hi_snap;
  logic [`GEI_DATA_W-1:0] stat_word;

  always_comb
  begin
    stat_word = '0;
    stat_word[`GEI_STAT_OVF_LOW_BIT] = q_ovf[0];
    stat_word[`GEI_STAT_OVF_HIGH_BIT] = q_ovf[1];
    stat_word[`GEI_STAT_FILL_LOW_LSB +: QAW + 1] = q_fill[0];
    stat_word[`GEI_STAT_FILL_HIGH_LSB +: QAW + 1] = q_fill[1];
    nxt_rdata = '0;
    nxt_qsel = 2'h0;
    pop = 2'h0;
    nxt_wait_hi_snap = wait_hi_snap_ff;
    if (rd_i)
    begin
      case (sel)
        GEI_REG_FWD_LO: nxt_rdata = fwd_ff[`GEI_LO_W-1:0];
        GEI_REG_FWD_HI: nxt_rdata = `GEI_DATA_W'(fwd_ff[`GEI_NSRC-1:`GEI_LO_W]);
        GEI_REG_LVL_LO: nxt_rdata = lvl_ff[`GEI_LO_W-1:0];
        GEI_REG_LVL_HI: nxt_rdata = `GEI_DATA_W'(lvl_ff[`GEI_NSRC-1:`GEI_LO_W]);
        GEI_REG_WAIT_LO:
        begin
          nxt_rdata = wait_ff[`GEI_LO_W-1:0];
          // High group is frozen here so both words describe one moment
          nxt_wait_hi_snap = wait_ff[`GEI_NSRC-1:`GEI_LO_W];
        end
        GEI_REG_WAIT_HI: nxt_rdata = `GEI_DATA_W'(wait_hi_snap_ff);
        GEI_REG_QLOW:
        begin
          if (q_empty[0])
            nxt_rdata = `GEI_DATA_W'(`GEI_CODE_EMPTY);
          else
          begin
            nxt_qsel[0] = 1'b1;
            pop[0] = 1'b1;
          end
        end
        GEI_REG_QHIGH:
        begin
          if (q_empty[1])
            nxt_rdata = `GEI_DATA_W'(`GEI_CODE_EMPTY);
          else
          begin
            nxt_qsel[1] = 1'b1;
            pop[1] = 1'b1;
          end
        end
        GEI_REG_QSTAT: nxt_rdata = stat_word;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= '0;
      qsel_ff <= 2'h0;
      wait_hi_snap_ff <= '0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      qsel_ff <= nxt_qsel;
      wait_hi_snap_ff <= nxt_wait_hi_snap;
    end
  end

  // Queue words come straight from the memory's read register
  assign rdata_o = qsel_ff[0] ? `GEI_DATA_W'(q_rdata[0]) :
                   qsel_ff[1] ? `GEI_DATA_W'(q_rdata[1]) :
                   rdata_ff;

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  assign processor_irq_o = |(wait_ff & fwd_ff);
  assign irq_low_o = !q_empty[0];
  assign irq_high_o = !q_empty[1];

endmodule

`default_nettype wire

// File: gei_top_asserts.sv
// Port-level checker of the event interrupt controller, bound to gei_top.
// Assumes the register map header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "gei_map.svh"

module gei_top_asserts #(
  parameter int QAW = 6
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Events
  input wire logic [35:0] channel_event_i,
  input wire logic pulse_per_second_i,
  input wire logic antenna_switch_epoch_i,
  input wire logic measurement_epoch_i,
  input wire logic power_detector_real_i,
  input wire logic power_detector_complex_i,
  input wire logic transfer_error_i,
  // Requests
  input wire logic processor_irq_o,
  input wire logic irq_low_o,
  input wire logic irq_high_o
);
  localparam int QDEPTH = 1 << QAW;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire logic any_ev = (|channel_event_i) | pulse_per_second_i | antenna_switch_epoch_i | measurement_epoch_i
    | power_detector_real_i | power_detector_complex_i | transfer_error_i;
  wire logic rd_ql = rd_i && addr_i == `GEI_OFS_QLOW;
  wire logic rd_qh = rd_i && addr_i == `GEI_OFS_QHIGH;
  // Anything beyond the map or off word alignment
  wire logic rd_none = rd_i && (addr_i > `GEI_OFS_QSTAT || addr_i[1:0] != 2'h0);

  a_reset_quiet: assert property ($rose(rst_n_i) |-> !processor_irq_o && !irq_low_o && !irq_high_o)
    else $error("request line high right after reset");
  a_low_code: assert property (rd_ql |=> $past(irq_low_o) || rdata_o == 32'h3F)
    else $error("empty low queue read not 63");
  a_low_entry: assert property (rd_ql && irq_low_o |=> rdata_o < 32'd42)
    else $error("low queue entry out of code range");
  a_high_code: assert property (rd_qh |=> ($past(irq_high_o) ? rdata_o < 32'd42 : rdata_o == 32'h3F))
    else $error("bad high queue code");
  a_hi_reserved: assert property (rd_i && addr_i inside {8'h04, 8'h0C, 8'h14} |=> rdata_o[31:10] == 22'h0)
    else $error("reserved upper bits not zero");
  a_ack_wo: assert property (rd_i && addr_i inside {8'h18, 8'h1C} |=> rdata_o == 32'h0)
    else $error("acknowledge register readable");
  a_unmapped_zero: assert property (rd_none |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_stat_fields: assert property (rd_i && addr_i == `GEI_OFS_QSTAT |=> rdata_o[31:16] == 16'h0
    && rdata_o[13:7] <= QDEPTH && rdata_o[6:0] <= QDEPTH)
    else $error("queue status field out of range");
  a_low_drain: assert property ($fell(irq_low_o) |-> $past(rd_ql))
    else $error("low queue emptied without read");
  a_high_drain: assert property ($fell(irq_high_o) |-> $past(rd_qh))
    else $error("high queue emptied without read");
  a_fwd_cause: assert property ($rose(processor_irq_o) |-> $past(any_ev || wr_i))
    else $error("processor request without cause");

  c_low_pop: cover property (rd_ql && irq_low_o);
  c_high_pop: cover property (rd_qh && irq_high_o);
  c_fwd: cover property ($rose(processor_irq_o));
endmodule

bind gei_top gei_top_asserts #(.QAW(QAW)) gei_top_asserts_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .channel_event_i(channel_event_i), .pulse_per_second_i(pulse_per_second_i),
  .antenna_switch_epoch_i(antenna_switch_epoch_i), .measurement_epoch_i(measurement_epoch_i),
  .power_detector_real_i(power_detector_real_i), .power_detector_complex_i(power_detector_complex_i),
  .transfer_error_i(transfer_error_i), .processor_irq_o(processor_irq_o), .irq_low_o(irq_low_o),
  .irq_high_o(irq_high_o));

`default_nettype wire

// File: tb_gei_top.sv
// Self-checking bench of the event interrupt controller over its register port.
// Assumes gei_pkg, gei_top and the processor-side model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "gei_map.svh"

module tb_gei_top;
  import gei_pkg::*;
  // Small queues so overflow is reached quickly
  localparam int QAW = 2;
  localparam int QDEPTH = 1 << QAW;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata_o;
  gei_src_t src = '0;
  logic processor_irq_o;
  logic irq_low_o;
  logic irq_high_o;
  logic seen_low;
  logic seen_high;
  int miscompares = 0;
  int checked = 0;

  gei_top #(.QAW(QAW)) gei_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata_o), .channel_event_i(src[35:0]), .pulse_per_second_i(src[36]),
    .antenna_switch_epoch_i(src[37]), .measurement_epoch_i(src[38]), .power_detector_real_i(src[39]),
    .power_detector_complex_i(src[40]), .transfer_error_i(src[41]), .processor_irq_o(processor_irq_o),
    .irq_low_o(irq_low_o), .irq_high_o(irq_high_o));
  gei_cpu_model gei_cpu_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .irq_low_i(irq_low_o),
    .irq_high_i(irq_high_o), .seen_low_o(seen_low), .seen_high_o(seen_high));

  initial
  begin
    forever #2 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask
  // One-cycle event pulse; returns just after the edge that takes it
  task automatic pulse(input int i);
    @(posedge clock_i);
    src <= gei_src_t'(1) << i;
    @(posedge clock_i);
    src <= '0;
    #1;
  endtask
  task automatic conclude();
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a <= 28; a += 4) rdc(a[7:0], 32'h0);
    rdc(`GEI_OFS_QLOW, 32'h3F);
    rdc(`GEI_OFS_QSTAT, 32'h0);
    wr(`GEI_OFS_LVL_LO, 32'hFFFFFFFF);
    rdc(`GEI_OFS_LVL_LO, 32'hFFFFFFFF);
    wr(`GEI_OFS_LVL_HI, 32'hFFFFFFFF);
    rdc(`GEI_OFS_LVL_HI, 32'h3FF);
    wr(`GEI_OFS_LVL_LO, 32'h0);
    // Forwarding off: recorded only
    pulse(3);
    chk({31'h0, processor_irq_o}, 32'h0);
    rdc(`GEI_OFS_WAIT_LO, 32'h8);
    rdc(`GEI_OFS_QLOW, 32'h3F);
    wr(`GEI_OFS_WAIT_LO, 32'hFFFFFFFF);
    rdc(`GEI_OFS_WAIT_LO, 32'h8);
    wr(`GEI_OFS_ACK_LO, 32'hFFFFFFF7);
    rdc(`GEI_OFS_WAIT_LO, 32'h8);
    wr(`GEI_OFS_ACK_LO, 32'h8);
    rdc(`GEI_OFS_WAIT_LO, 32'h0);
    // Forwarding on, low level
    wr(`GEI_OFS_FWD_LO, 32'h80);
    pulse(7);
    chk({31'h0, processor_irq_o}, 32'h1);
    repeat (2) @(posedge clock_i);
    #1;
    chk({31'h0, irq_low_o}, 32'h1);
    rdc(`GEI_OFS_QLOW, 32'h7);
    rdc(`GEI_OFS_QLOW, 32'h3F);
    wr(`GEI_OFS_ACK_LO, 32'h80);
    chk({31'h0, processor_irq_o}, 32'h0);
    // Second group, high level, every source
    wr(`GEI_OFS_FWD_HI, 32'h3FF);
    rdc(`GEI_OFS_FWD_HI, 32'h3FF);
    for (int i = 0; i < 10; i++)
    begin
      pulse(32 + i);
      rdc(`GEI_OFS_WAIT_LO, 32'h0);
      rdc(`GEI_OFS_WAIT_HI, 32'h1 << i);
      rdc(`GEI_OFS_QHIGH, 32 + i);
      wr(`GEI_OFS_ACK_HI, 32'h1 << i);
    end
    rdc(`GEI_OFS_QHIGH, 32'h3F);
    // Overflow of the low queue
    wr(`GEI_OFS_FWD_HI, 32'h0);
    wr(`GEI_OFS_FWD_LO, 32'h1);
    repeat (QDEPTH + 1) pulse(0);
    repeat (2) @(posedge clock_i);
    rdc(`GEI_OFS_QSTAT, 32'h8000 | (QDEPTH << 7));
    wr(`GEI_OFS_QSTAT, 32'h8000);
    rdc(`GEI_OFS_QSTAT, QDEPTH << 7);
    repeat (QDEPTH) rdc(`GEI_OFS_QLOW, 32'h0);
    rdc(`GEI_OFS_QLOW, 32'h3F);
    rdc(`GEI_OFS_QSTAT, 32'h0);
    rdc(`GEI_OFS_FWD_LO, 32'h1);
    // Overflow of the high queue, same source moved up a level
    wr(`GEI_OFS_LVL_LO, 32'h1);
    repeat (QDEPTH + 1) pulse(0);
    repeat (2) @(posedge clock_i);
    #1;
    chk({31'h0, irq_high_o}, 32'h1);
    rdc(`GEI_OFS_QSTAT, 32'h4000 | QDEPTH);
    wr(`GEI_OFS_QSTAT, 32'h4000);
    rdc(`GEI_OFS_QSTAT, QDEPTH);
    repeat (QDEPTH) rdc(`GEI_OFS_QHIGH, 32'h0);
    rdc(`GEI_OFS_QHIGH, 32'h3F);
    wr(8'h2C, 32'hFFFFFFFF);
    rdc(8'h2C, 32'h0);
    rdc(8'h01, 32'h0);
    chk({30'h0, seen_high, seen_low}, 32'h3);
    conclude();
  end

  // Whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    conclude();
  end
endmodule

`default_nettype wire
